// ===== host_port_pkg.sv
// Constants, offsets and state types of the host port block
// Behaviour
// RL1: Width-select low means 16-bit, high 8-bit
// RL2: Boot-source low EPROM boot, high host boot
// RL3: Strobe-style picks separate strobes or direction+qualifier
// RL4: First control: read strobe or direction select
// RL5: Second control: write strobe or data qualifier
// RL6: Arrangement low separate, high multiplexed address/data
// RL7: Sixteen two-way lines carry data, or address too
// RL8: Address bit two, or latch enable when multiplexed
// RL9: Low address bits used only in separate mode
// RL10: Distinct host write/read interrupts, not software-controllable
// RL11: Select per access; acknowledge lets access complete
package host_port_pkg;
    localparam int          DATA_W         = 16;
    localparam int          NUM_PORT_REGS  = 8;
    localparam int          SYNC_W         = 26;
    localparam int          SYNC_STAGES    = 2;
    localparam logic [1:0]  CFG_WAIT_CYC   = 2'h2;
    localparam logic [25:0] SYNC_RST_VAL   = 26'h380_0000;
    localparam logic [15:0] PORT_REG_RST   = 16'h0000;
    localparam logic [7:0]  OFS_PORT_DATA0 = 8'h00;
    localparam logic [7:0]  OFS_PORT_LAST  = 8'h1C;
    localparam logic [7:0]  OFS_STATUS     = 8'h20;
    localparam int          STS_WIDTH_BIT  = 0;
    localparam int          STS_BOOT_BIT   = 1;
    localparam int          STS_STYLE_BIT  = 2;
    localparam int          STS_MUX_BIT    = 3;
    localparam int          STS_PHASE_BIT  = 4;
    localparam int          STS_BUSY_BIT   = 5;
    typedef enum logic {ST_IDLE, ST_ACK} host_state_t;
endpackage

// ===== host_port_sync.sv
// Two-flop synchroniser for pin inputs
module host_port_sync #(
    parameter int                 W       = 1,
    parameter logic [W-1:0]       RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

// ===== host_port.sv
// Parallel host port with strap decode and Wishbone core side
//
// Added by the designer: the placing of the registers and the Wishbone register port.
module host_port (
    input  wire logic        MCLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        PORT_SELECT_N_I,
    input  wire logic        HOST_RD_OR_DIR_I,
    input  wire logic        HOST_WR_OR_QUAL_I,
    input  wire logic [15:0] HOST_DATA_LINES_I,
    output logic      [15:0] HOST_DATA_LINES_O,
    output logic             HOST_DATA_LINES_OE_O,
    input  wire logic        PORT_ADDR_BIT_TWO_I,
    input  wire logic [1:0]  PORT_ADDR_LOW_BITS_I,
    output logic             PORT_ACK_N_O,
    input  wire logic        WIDTH_SELECT_I,
    input  wire logic        BOOT_SOURCE_SELECT_I,
    input  wire logic        STROBE_STYLE_SELECT_I,
    input  wire logic        ADDR_DATA_ARRANGEMENT_SELECT_I,
    output logic             BOOT_FROM_HOST_O,
    output logic             HOST_WRITE_IRQ_O,
    output logic             HOST_READ_IRQ_O
);
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    logic [25:0]              sync_q;
    logic                     sel_n_s;
    logic                     ctl0_s;
    logic                     ctl1_s;
    logic                     a2_s;
    logic [1:0]               alow_s;
    logic [15:0]              data_s;
    logic [3:0]               strap_s;

    host_port_sync #(.W(host_port_pkg::SYNC_W), .RST_VAL(host_port_pkg::SYNC_RST_VAL)) u_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .d_i     ({PORT_SELECT_N_I, HOST_RD_OR_DIR_I, HOST_WR_OR_QUAL_I, PORT_ADDR_BIT_TWO_I,
                   PORT_ADDR_LOW_BITS_I, HOST_DATA_LINES_I, WIDTH_SELECT_I,
                   BOOT_SOURCE_SELECT_I, STROBE_STYLE_SELECT_I,
                   ADDR_DATA_ARRANGEMENT_SELECT_I}),
        .q_o     (sync_q)
    );
    assign {sel_n_s, ctl0_s, ctl1_s, a2_s, alow_s, data_s, strap_s} = sync_q;

    // Strap capture after reset release
    logic [1:0]               cfg_cnt_ff;
    logic [1:0]               nxt_cfg_cnt;
    logic                     cfg_valid_ff;
    logic                     nxt_cfg_valid;
    logic                     width8_ff;
    logic                     nxt_width8;
    logic                     style_ff;
    logic                     nxt_style;
    logic                     mux_ff;
    logic                     nxt_mux;
    logic                     boot_ff;
    logic                     nxt_boot;

    always_comb begin
        nxt_cfg_cnt   = cfg_cnt_ff;
        nxt_cfg_valid = cfg_valid_ff;
        nxt_width8    = width8_ff;
        nxt_boot      = boot_ff;
        nxt_style     = style_ff;
        nxt_mux       = mux_ff;
        if (!cfg_valid_ff) begin
            if (cfg_cnt_ff == host_port_pkg::CFG_WAIT_CYC) begin
                nxt_cfg_valid = 1'b1;
                nxt_width8    = strap_s[3]; // [RL1]
                nxt_boot      = strap_s[2]; // [RL2]
                nxt_style     = strap_s[1]; // [RL3]
                nxt_mux       = strap_s[0]; // [RL6]
            end else begin
                nxt_cfg_cnt = cfg_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cfg_cnt_ff   <= 2'h0;
            cfg_valid_ff <= 1'b0;
            width8_ff    <= 1'b0;
            boot_ff      <= 1'b0;
            style_ff     <= 1'b0;
            mux_ff       <= 1'b0;
        end else begin
            cfg_cnt_ff   <= nxt_cfg_cnt;
            cfg_valid_ff <= nxt_cfg_valid;
            width8_ff    <= nxt_width8;
            boot_ff      <= nxt_boot;
            style_ff     <= nxt_style;
            mux_ff       <= nxt_mux;
        end
    end
    assign BOOT_FROM_HOST_O = boot_ff; // [RL2]

    // Host access decode
    logic                     rd_req;
    logic                     wr_req;
    logic                     access;
    logic [2:0]               cur_addr;

    always_comb begin
        if (style_ff) begin
            rd_req = !ctl1_s && ctl0_s;  // [RL4] [RL5]
            wr_req = !ctl1_s && !ctl0_s; // [RL4] [RL5]
        end else begin
            rd_req = !ctl0_s;            // [RL4]
            wr_req = !ctl1_s;            // [RL5]
        end
        access = cfg_valid_ff && !sel_n_s && (rd_req || wr_req); // [RL11]
    end

    // Host state, port registers and core bus
    host_port_pkg::host_state_t state_ff;
    host_port_pkg::host_state_t nxt_state;
    logic [15:0]              port_mem_ff [host_port_pkg::NUM_PORT_REGS];
    logic [15:0]              nxt_port_mem [host_port_pkg::NUM_PORT_REGS];
    logic [2:0]               addr_latch_ff;
    logic [2:0]               nxt_addr_latch;
    logic                     phase_ff;
    logic                     nxt_phase;
    logic [15:0]              dout_ff;
    logic [15:0]              nxt_dout;
    logic                     oe_ff;
    logic                     nxt_oe;
    logic                     ack_n_ff;
    logic                     nxt_ack_n;
    logic                     wirq_ff;
    logic                     nxt_wirq;
    logic                     rirq_ff;
    logic                     nxt_rirq;
    logic                     wb_ack_ff;
    logic                     nxt_wb_ack;
    logic [31:0]              wb_dat_ff;
    logic [31:0]              nxt_wb_dat;
    logic [1:0]               host_be;
    logic                     word_done;

    always_comb begin
        cur_addr = mux_ff ? addr_latch_ff : {a2_s, alow_s}; // [RL8] [RL9]
        nxt_addr_latch = addr_latch_ff;
        if (mux_ff && a2_s) begin
            nxt_addr_latch = data_s[2:0]; // [RL8] [RL7]
        end
        host_be   = width8_ff ? (phase_ff ? 2'b10 : 2'b01) : 2'b11; // [RL1]
        word_done = !width8_ff || phase_ff;
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_dout  = dout_ff;
        nxt_oe    = oe_ff;
        nxt_ack_n = ack_n_ff;
        nxt_wirq  = 1'b0;
        nxt_rirq  = 1'b0;
        for (int i = 0; i < host_port_pkg::NUM_PORT_REGS; i++) begin
            nxt_port_mem[i] = port_mem_ff[i];
        end
        nxt_wb_ack = CYC_I && STB_I && !wb_ack_ff;
        nxt_wb_dat = wb_dat_ff;
        if (nxt_wb_ack) begin
            nxt_wb_dat = 32'h0000_0000;
            if (ADR_I <= host_port_pkg::OFS_PORT_LAST && ADR_I[1:0] == 2'b00) begin
                nxt_wb_dat[15:0] = port_mem_ff[ADR_I[4:2]];
                if (WE_I) begin
                    nxt_port_mem[ADR_I[4:2]] = merge16(port_mem_ff[ADR_I[4:2]],
                                                       DAT_I[15:0], SEL_I[1:0]);
                end
            end else if (ADR_I == host_port_pkg::OFS_STATUS) begin
                nxt_wb_dat[host_port_pkg::STS_WIDTH_BIT] = width8_ff;
                nxt_wb_dat[host_port_pkg::STS_BOOT_BIT]  = boot_ff;
                nxt_wb_dat[host_port_pkg::STS_STYLE_BIT] = style_ff;
                nxt_wb_dat[host_port_pkg::STS_MUX_BIT]   = mux_ff;
                nxt_wb_dat[host_port_pkg::STS_PHASE_BIT] = phase_ff;
                nxt_wb_dat[host_port_pkg::STS_BUSY_BIT]  = (state_ff == host_port_pkg::ST_ACK);
            end
        end
        case (state_ff)
            host_port_pkg::ST_IDLE: begin
                if (access) begin
                    nxt_state = host_port_pkg::ST_ACK;
                    nxt_ack_n = 1'b0; // [RL11]
                    if (width8_ff) begin
                        nxt_phase = !phase_ff; // [RL1]
                    end
                    if (wr_req) begin
                        nxt_port_mem[cur_addr] = merge16(port_mem_ff[cur_addr],
                                                         width8_ff ? {2{data_s[7:0]}} : data_s,
                                                         host_be);
                        nxt_wirq = word_done; // [RL10]
                    end else begin
                        nxt_oe   = 1'b1; // [RL7]
                        nxt_dout = width8_ff ? {8'h00, phase_ff ? port_mem_ff[cur_addr][15:8]
                                                                : port_mem_ff[cur_addr][7:0]}
                                             : port_mem_ff[cur_addr];
                        nxt_rirq = word_done; // [RL10]
                    end
                end
            end
            host_port_pkg::ST_ACK: begin
                if (!access) begin
                    nxt_state = host_port_pkg::ST_IDLE;
                    nxt_ack_n = 1'b1; // [RL11]
                    nxt_oe    = 1'b0;
                end
            end
            default: begin
                nxt_state = host_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff      <= host_port_pkg::ST_IDLE;
            addr_latch_ff <= 3'h0;
            phase_ff      <= 1'b0;
            dout_ff       <= 16'h0000;
            oe_ff         <= 1'b0;
            ack_n_ff      <= 1'b1;
            wirq_ff       <= 1'b0;
            rirq_ff       <= 1'b0;
            wb_ack_ff     <= 1'b0;
            wb_dat_ff     <= 32'h0000_0000;
            for (int i = 0; i < host_port_pkg::NUM_PORT_REGS; i++) begin
                port_mem_ff[i] <= host_port_pkg::PORT_REG_RST;
            end
        end else begin
            state_ff      <= nxt_state;
            addr_latch_ff <= nxt_addr_latch;
            phase_ff      <= nxt_phase;
            dout_ff       <= nxt_dout;
            oe_ff         <= nxt_oe;
            ack_n_ff      <= nxt_ack_n;
            wirq_ff       <= nxt_wirq;
            rirq_ff       <= nxt_rirq;
            wb_ack_ff     <= nxt_wb_ack;
            wb_dat_ff     <= nxt_wb_dat;
            for (int i = 0; i < host_port_pkg::NUM_PORT_REGS; i++) begin
                port_mem_ff[i] <= nxt_port_mem[i];
            end
        end
    end

    assign HOST_DATA_LINES_O    = dout_ff;
    assign HOST_DATA_LINES_OE_O = oe_ff;
    assign PORT_ACK_N_O         = ack_n_ff;
    assign HOST_WRITE_IRQ_O     = wirq_ff;
    assign HOST_READ_IRQ_O      = rirq_ff;
    assign ACK_O                = wb_ack_ff;
    assign DAT_O                = wb_dat_ff;

    // Checks
    sequence s_host_start;
        state_ff == host_port_pkg::ST_IDLE && access;
    endsequence
    sequence s_host_end;
        state_ff == host_port_pkg::ST_ACK && !access;
    endsequence

    property p_ack_on_start;
        @(posedge MCLK_I) disable iff (!RST_N_I) s_host_start |=> !PORT_ACK_N_O;
    endproperty
    a_ack_on_start: assert property (p_ack_on_start) else $error("ack not given"); // [RL11]

    property p_ack_release;
        @(posedge MCLK_I) disable iff (!RST_N_I) s_host_end |=> PORT_ACK_N_O && !HOST_DATA_LINES_OE_O;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack not released"); // [RL11]

    property p_write_irq;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (s_host_start and (wr_req && word_done)) |=> HOST_WRITE_IRQ_O ##1 !HOST_WRITE_IRQ_O;
    endproperty
    a_write_irq: assert property (p_write_irq) else $error("write irq wrong"); // [RL10]

    property p_read_irq;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (s_host_start and (!wr_req && word_done)) |=> HOST_READ_IRQ_O && !HOST_WRITE_IRQ_O;
    endproperty
    a_read_irq: assert property (p_read_irq) else $error("read irq wrong"); // [RL10]

    property p_dir_style_read;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (s_host_start and (style_ff && ctl0_s)) |=> HOST_DATA_LINES_OE_O;
    endproperty
    a_dir_style_read: assert property (p_dir_style_read) else $error("no drive"); // [RL3] [RL4]

    property p_sep_write;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (s_host_start and (!style_ff && !ctl1_s && ctl0_s)) |=> !HOST_DATA_LINES_OE_O;
    endproperty
    a_sep_write: assert property (p_sep_write) else $error("write drove lines"); // [RL5]

    property p_byte_width;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (HOST_DATA_LINES_OE_O && width8_ff) |-> HOST_DATA_LINES_O[15:8] == 8'h00;
    endproperty
    a_byte_width: assert property (p_byte_width) else $error("upper byte driven"); // [RL1]

    property p_ale_latch;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (mux_ff && a2_s) |=> addr_latch_ff == $past(data_s[2:0]);
    endproperty
    a_ale_latch: assert property (p_ale_latch) else $error("address not latched"); // [RL8]

    // Separate-mode word write lands at the pin address
    property p_sep_addr;
        @(posedge MCLK_I) disable iff (!RST_N_I)
            (s_host_start and (!mux_ff && wr_req && !width8_ff))
            |=> port_mem_ff[{$past(a2_s), $past(alow_s)}] == $past(data_s);
    endproperty
    a_sep_addr: assert property (p_sep_addr) else $error("address source wrong"); // [RL9]

    property p_wb_ack;
        @(posedge MCLK_I) disable iff (!RST_N_I) (CYC_I && STB_I && !ACK_O) |=> ACK_O;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack missing"); // Wishbone port added by the designer
endmodule

// ===== host_model.sv
// Host processor model driving the parallel host port pins
module host_model (
    input  wire logic        clk_i,
    input  wire logic        style_i,
    input  wire logic        mux_i,
    input  wire logic        width8_i,
    input  wire logic [15:0] bus_i,
    input  wire logic        ack_n_i,
    output logic             sel_n_o,
    output logic             ctl_a_o,
    output logic             ctl_b_o,
    output logic      [15:0] drv_o,
    output logic             a2_o,
    output logic      [1:0]  alo_o,
    output logic             timeout_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_n_o = 1'b1;
        ctl_a_o = 1'b1;
        ctl_b_o = 1'b1;
        drv_o = 16'h0000;
        a2_o = 1'b0;
        alo_o = 2'h0;
        timeout_o = 1'b0;
    end
    // Bounded wait for the acknowledge level
    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (ack_n_i !== lvl && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) timeout_o <= 1'b1;
    endtask
    // One unit: select and strobes held until acknowledged
    task automatic unit(input logic rd, input logic [15:0] wd, output logic [15:0] q);
        sel_n_o <= 1'b0;
        drv_o <= rd ? ~drv_o : wd;
        ctl_a_o <= style_i ? rd : ~rd;
        ctl_b_o <= style_i ? 1'b0 : rd;
        @(posedge clk_i);
        wait_ack(1'b0);
        q = bus_i;
        sel_n_o <= 1'b1;
        ctl_a_o <= 1'b1;
        ctl_b_o <= 1'b1;
        drv_o <= ~drv_o;
        @(posedge clk_i);
        wait_ack(1'b1);
    endtask
    // Whole access in the arrangement and width the straps select
    task automatic access(input logic rd, input logic [2:0] adr, input logic [15:0] wd,
                          output logic [15:0] rq);
        logic [15:0] q0;
        logic [15:0] q1;
        if (mux_i) begin
            drv_o <= {13'h0ab5, adr};
            a2_o <= 1'b1;
            alo_o <= ~adr[1:0];
            repeat (3) @(posedge clk_i);
            a2_o <= 1'b0;
            @(posedge clk_i);
        end else begin
            a2_o <= adr[2];
            alo_o <= adr[1:0];
        end
        if (width8_i) begin
            unit(rd, {~wd[7:0], wd[7:0]}, q0);
            unit(rd, {~wd[15:8], wd[15:8]}, q1);
            rq = {q1[7:0], q0[7:0]};
        end else begin
            unit(rd, wd, rq);
        end
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the host port block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic [3:0]  cfg;
    logic [3:0]  bsel = 4'h3;
    logic        sel_n;
    logic        ctl_a;
    logic        ctl_b;
    logic [15:0] drv;
    logic [15:0] dout;
    logic [15:0] bus;
    logic        oe;
    logic        a2;
    logic [1:0]  alo;
    logic        ack_n;
    logic        boot;
    logic        wirq;
    logic        rirq;
    logic        host_to;
    int          wcnt = 0;
    int          rcnt = 0;
    int          cycles = 0;
    int          failures = 0;
    int          checked = 0;
    assign bus = oe ? dout : drv;
    host_port host_port_i (
        .MCLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .PORT_SELECT_N_I(sel_n), .HOST_RD_OR_DIR_I(ctl_a), .HOST_WR_OR_QUAL_I(ctl_b),
        .HOST_DATA_LINES_I(bus), .HOST_DATA_LINES_O(dout), .HOST_DATA_LINES_OE_O(oe),
        .PORT_ADDR_BIT_TWO_I(a2), .PORT_ADDR_LOW_BITS_I(alo), .PORT_ACK_N_O(ack_n),
        .WIDTH_SELECT_I(cfg[0]), .BOOT_SOURCE_SELECT_I(cfg[1]),
        .STROBE_STYLE_SELECT_I(cfg[2]), .ADDR_DATA_ARRANGEMENT_SELECT_I(cfg[3]),
        .BOOT_FROM_HOST_O(boot), .HOST_WRITE_IRQ_O(wirq), .HOST_READ_IRQ_O(rirq)
    );
    host_model host_i (
        .clk_i(clk), .style_i(cfg[2]), .mux_i(cfg[3]), .width8_i(cfg[0]), .bus_i(bus),
        .ack_n_i(ack_n), .sel_n_o(sel_n), .ctl_a_o(ctl_a), .ctl_b_o(ctl_b), .drv_o(drv),
        .a2_o(a2), .alo_o(alo), .timeout_o(host_to)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic final_report();
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Interrupt pulse counters and run ceiling
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wirq === 1'b1) wcnt <= wcnt + 1;
        if (rirq === 1'b1) rcnt <= rcnt + 1;
        if (cycles == 6000) begin
            failures++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Classic Wishbone single cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= bsel;
        adr <= a;
        dat_w <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) failures++;
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset(input logic [3:0] c);
        rst_n <= 1'b0;
        cfg <= c;
        repeat (10) @(posedge clk);
        check("boot in reset", 32'h0000_0000, 32'(boot));
        check("ack in reset", 32'h0000_0001, 32'(ack_n));
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    initial begin
        logic [31:0] q;
        logic [15:0] hq;
        logic [15:0] d;
        logic [2:0]  a;
        int          w0;
        int          r0;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h3;
        dat_w = 32'h0000_0000;
        cfg = 4'h0;
        for (int i = 0; i < 16; i++) begin
            do_reset(i[3:0]);
            d = 16'h1234 ^ {4{i[3:0]}};
            a = i[2:0] ^ 3'h5;
            check("boot", 32'(i[1]), 32'(boot));
            check("oe idle", 32'h0000_0000, 32'(oe));
            wb(1'b0, host_port_pkg::OFS_STATUS, 32'h0000_0000, q);
            check("status", 32'(i[3:0]), q);
            w0 = wcnt;
            r0 = rcnt;
            host_i.access(1'b0, a, d, hq);
            check("write irq", 32'(w0 + 1), 32'(wcnt));
            check("read irq idle", 32'(r0), 32'(rcnt));
            wb(1'b0, host_port_pkg::OFS_PORT_DATA0 + {3'h0, a, 2'h0}, 32'h0000_0000, q);
            check("host write", {16'h0000, d}, q);
            wb(1'b1, host_port_pkg::OFS_PORT_DATA0 + {3'h0, ~a, 2'h0}, {16'h0000, ~d},
               q);
            host_i.access(1'b1, ~a, 16'h0000, hq);
            check("host read", {16'h0000, ~d}, {16'h0000, hq});
            check("read irq", 32'(r0 + 1), 32'(rcnt));
            check("write irq once", 32'(w0 + 1), 32'(wcnt));
            check("oe after", 32'h0000_0000, 32'(oe));
        end
        wb(1'b1, host_port_pkg::OFS_STATUS, 32'h0000_FFFF, q);
        wb(1'b0, host_port_pkg::OFS_STATUS, 32'h0000_0000, q);
        check("status kept", 32'h0000_000F, q);
        // Byte-enable write touches only the low byte
        bsel = 4'h1;
        wb(1'b1, host_port_pkg::OFS_PORT_DATA0, 32'h0000_ABCD, q);
        bsel = 4'h3;
        wb(1'b0, host_port_pkg::OFS_PORT_DATA0, 32'h0000_0000, q);
        check("byte enable", 32'h0000_00CD, q);
        wb(1'b0, 8'h40, 32'h0000_0000, q);
        check("unmapped", 32'h0000_0000, q);
        check("host timeout", 32'h0000_0000, 32'(host_to));
        final_report();
    end
endmodule
